// [bench/tb.sv]
// bench top: axi4-lite master tasks and scenarios for the otg session block
// assumes the far-side model drives all usb status and event lines
`timescale 1ns/10ps
`include "usb_otg_params.svh"
module tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    // raised by the bus tasks and then left high: responses never stall
    logic bready = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic role_is_a, host_mode, module_suspended, session_in_progress, hs_resume_end;
    logic chirp_begin, chirp_end, hs_wait_begin, hs_wait_end;
    logic session_drive, srp_start, soft_disconnect, transceiver_normal_en, chirp_timeout, hs_timeout;
    logic [17:0] chirp_limit_o, hs_limit_o;
    int failures = 0;
    int checks_done = 0;

    usb_otg_session dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .role_is_a(role_is_a),
        .host_mode(host_mode), .module_suspended(module_suspended), .session_in_progress(session_in_progress),
        .hs_resume_end(hs_resume_end), .chirp_begin(chirp_begin), .chirp_end(chirp_end),
        .hs_wait_begin(hs_wait_begin), .hs_wait_end(hs_wait_end), .session_drive(session_drive),
        .srp_start(srp_start), .soft_disconnect(soft_disconnect), .transceiver_normal_en(transceiver_normal_en),
        .chirp_timeout(chirp_timeout), .hs_timeout(hs_timeout), .chirp_limit_o(chirp_limit_o),
        .hs_limit_o(hs_limit_o));

    usb_far_side far (.aclk(aclk), .aresetn(aresetn), .srp_start(srp_start), .soft_disconnect(soft_disconnect),
        .role_is_a(role_is_a), .host_mode(host_mode), .module_suspended(module_suspended),
        .session_in_progress(session_in_progress), .hs_resume_end(hs_resume_end), .chirp_begin(chirp_begin),
        .chirp_end(chirp_end), .hs_wait_begin(hs_wait_begin), .hs_wait_end(hs_wait_end));

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        failures++;
        $display("mismatch %s expected handshake seen timeout", what);
        results();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hF);
        logic done;
        done = 1'h0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        bready <= 1'h1;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                r = bresp;
                done = 1'h1;
            end
        end
        if (!done) hang("write response");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                d = rdata;
                r = rresp;
                done = 1'h1;
            end
        end
        if (!done) hang("read response");
    endtask

    // edges until the chosen output is high: 0 chirp, 1 hs, 2 normal mode; 0 if never
    task automatic wait_for(input int which, input int lim, output int n);
        logic [2:0] s;
        for (n = 1; n <= lim; n++) begin
            @(posedge aclk);
            #1;
            s = {transceiver_normal_en, hs_timeout, chirp_timeout};
            if (s[which] === 1'h1) return;
        end
        n = 0;
    endtask

    // 736 plus 64 per step bit times, 133/64 ns each, rounded up to 8 ns cycles
    function automatic logic [31:0] hs_cycles(input int adder);
        return 32'(((736 + 64 * adder) * 133 + 511) / 512);
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(`TMCON1_OFS, d, r);
        chk("tm1 reset", 32'h05E6_4074, d);
        wr(`TMCON1_OFS, 32'h1234_5678, r, 4'h1);
        rd(`TMCON1_OFS, d, r);
        chk("tm1 low lane only", 32'h05E6_4078, d);
        rd(`TMCON2_OFS, d, r);
        chk("tm2 reset", 32'h0, d);
        wr(`TMCON2_OFS, 32'hFFFF_FFFF, r);
        rd(`TMCON2_OFS, d, r);
        chk("tm2 upper bits", 32'h0000_000F, d);
        wr(8'h10, 32'h1, r);
        chk("unmapped write resp", 32'(`AXI_SLVERR), 32'(r));
        rd(8'h10, d, r);
        chk("unmapped read resp", 32'(`AXI_SLVERR), 32'(r));
        $display("test regs done");
    endtask

    task automatic test_session();
        logic [31:0] d;
        logic [1:0] r;
        far.set_mode(1'h1, 1'h0, 1'h0);
        wr(`OTG_CTRL_OFS, 32'h1, r);
        chk("a session on", 32'h1, 32'(session_drive));
        rd(`OTG_CTRL_OFS, d, r);
        chk("a session read", 32'h1, d);
        wr(`OTG_CTRL_OFS, 32'h0, r);
        chk("a session off", 32'h0, 32'(session_drive));
        far.set_mode(1'h0, 1'h0, 1'h0);
        wr(`OTG_CTRL_OFS, 32'h1, r);
        rd(`OTG_CTRL_OFS, d, r);
        chk("b session read", 32'h1, d);
        // suspend first: clearing while active is left without effect
        far.set_mode(1'h0, 1'h0, 1'h1);
        wr(`OTG_CTRL_OFS, 32'h0, r);
        rd(`OTG_CTRL_OFS, d, r);
        chk("b session dropped", 32'h0, d);
        chk("srp pulses", 32'h1, 32'(far.srp_seen));
        chk("disconnect pulses", 32'h1, 32'(far.disc_seen));
        $display("test session done");
    endtask

    task automatic test_timers();
        int n;
        logic [1:0] r;
        wr(`TMCON1_OFS, 32'h0003_0002, r);
        wr(`TMCON2_OFS, 32'h0000_000F, r);
        @(posedge aclk);
        chk("chirp limit", 32'h8, 32'(chirp_limit_o));
        chk("hs limit max", hs_cycles(15), 32'(hs_limit_o));
        wr(`TMCON2_OFS, 32'h0, r);
        @(posedge aclk);
        chk("hs limit min", hs_cycles(0), 32'(hs_limit_o));
        far.pulse(3);
        repeat (4) @(posedge aclk);
        far.pulse(3);
        wait_for(0, 600, n);
        chk("chirp restart cycles", 32'h8, 32'(n));
        far.pulse(1);
        wait_for(1, 600, n);
        chk("hs cycles", hs_cycles(0), 32'(n));
        far.pulse(1);
        repeat (3) @(posedge aclk);
        far.pulse(0);
        wait_for(1, 300, n);
        chk("hs stopped", 32'h0, 32'(n));
        $display("test timers done");
    endtask

    task automatic test_resume();
        int n;
        logic [31:0] d;
        logic [1:0] r;
        far.set_mode(1'h1, 1'h0, 1'h0);
        far.pulse(4);
        #1;
        chk("resume ignored off host", 32'h1, 32'(transceiver_normal_en));
        far.set_mode(1'h1, 1'h1, 1'h0);
        far.pulse(4);
        #1;
        chk("normal mode held off", 32'h0, 32'(transceiver_normal_en));
        wait_for(2, 100, n);
        chk("resume delay cycles", 32'h4, 32'(n));
        rd(`OTG_STAT_OFS, d, r);
        chk("status after resume", 32'h0000_0011, d);
        $display("test resume done");
    endtask

    // mid-run reset must bring the timing register back to its reset value
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0] r;
        wr(`TMCON1_OFS, 32'h0000_0001, r);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`TMCON1_OFS, d, r);
        chk("tm1 after reset", 32'h05E6_4074, d);
        $display("test reset done");
    endtask

    initial begin
        forever #4 aclk = ~aclk;
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        test_regs();
        test_session();
        test_timers();
        test_resume();
        test_reset();
        results();
    end
endmodule

// [bench/usb_far_side.sv]
// far-side model: usb bus partner driving role, suspend, session and bus timing events
// assumes its tasks are called just after a rising edge of aclk
`timescale 1ns/10ps
module usb_far_side (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic srp_start,
    input wire logic soft_disconnect,
    output logic role_is_a,
    output logic host_mode,
    output logic module_suspended,
    output logic session_in_progress,
    output logic hs_resume_end,
    output logic chirp_begin,
    output logic chirp_end,
    output logic hs_wait_begin,
    output logic hs_wait_end
);
    logic [4:0] ev = 5'h00;
    int srp_seen = 0;
    int disc_seen = 0;

    assign {hs_resume_end, chirp_begin, chirp_end, hs_wait_begin, hs_wait_end} = ev;

    initial begin
        role_is_a = 1'h0;
        host_mode = 1'h0;
        module_suspended = 1'h0;
        session_in_progress = 1'h0;
    end

    // ----------------------------------------
    // session answer
    // ----------------------------------------
    // a request pulse is answered one edge later, like a fast host
    always @(posedge aclk) begin
        if (srp_start === 1'h1) begin
            srp_seen <= srp_seen + 1;
            session_in_progress <= 1'h1;
        end
        if (soft_disconnect === 1'h1) begin
            disc_seen <= disc_seen + 1;
            session_in_progress <= 1'h0;
        end
    end

    task automatic set_mode(input logic a, input logic h, input logic s);
        role_is_a <= a;
        host_mode <= h;
        module_suspended <= s;
        @(posedge aclk);
    endtask

    // one-cycle event: 4 resume end, 3 chirp begin, 2 chirp end, 1 hs begin, 0 hs end
    task automatic pulse(input int idx);
        ev[idx] <= 1'h1;
        @(posedge aclk);
        ev <= 5'h00;
    endtask
endmodule

// [hw/otg_interval_timer.sv]
// interval timer: counts clock cycles from a start pulse up to a limit
// assumes start and stop are one-cycle pulses synchronous to aclk
`timescale 1ns/10ps
module otg_interval_timer #(
    parameter int WIDTH = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic stop,
    input wire logic [WIDTH-1:0] limit,
    output logic expired,
    output logic running
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic running;
        logic expired;
    } timer_state_s;

    timer_state_s st_reg;
    timer_state_s st_next;

    // ----------------------------------------
    // counting
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (start) begin
            st_next.count = '0;
            st_next.running = 1'b1;
        end else if (stop) begin
            st_next.running = 1'b0;
        end else if (st_reg.running) begin
            // a zero limit behaves as one cycle so the timer never hangs
            if ((st_reg.count + 1'b1) >= limit) begin
                st_next.expired = 1'b1;
                st_next.running = 1'b0;
            end else begin
                st_next.count = st_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;
    assign running = st_reg.running;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    restart_zero_a: assert property (start |=> st_reg.count == '0 && st_reg.running)
        else $error("timer did not restart from zero");
    expire_exact_a: assert property (expired |-> $past(st_reg.running) &&
        (($past(st_reg.count) + 1'b1) >= $past(limit)) && ($past(st_reg.count) + 2'd2 > $past(limit)))
        else $error("timer expired away from its limit");

endmodule

// [hw/usb_otg_params.svh]
// offsets, field positions, reset values and timing counts of the otg session and hs timing block
// assumes an axi4-lite master with 32-bit data and a 125 mhz aclk that is also the usb module clock
`ifndef USB_OTG_PARAMS_SVH
`define USB_OTG_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define OTG_CTRL_OFS 8'h00
`define TMCON1_OFS 8'h04
`define TMCON2_OFS 8'h08
`define OTG_STAT_OFS 8'h0C
`define SESSION_BIT 0
`define RESUME_DLY_LSB 16
`define CHIRP_TO_LSB 0
`define HS_ADDER_W 4
`define TMCON1_RST 32'h05E6_4074
`define TMCON2_RST 32'h0000_0000
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 125
`define CHIRP_MULT 4
`define HS_MIN_BITS 736
`define HS_STEP_BITS 64
`define HS_STEP_NS 133

`endif

// [hw/usb_otg_pkg.sv]
// types used by the otg session block for register select and state
// assumes the params header for field widths
package usb_otg_pkg;

    typedef enum logic [2:0] {
        sel_none = 3'b000,
        sel_ctrl = 3'b001,
        sel_tm1 = 3'b011,
        sel_tm2 = 3'b010,
        sel_stat = 3'b110
    } reg_sel_e;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic session_a;
        logic srp_pulse;
        logic disc_pulse;
        logic normal_en;
        logic [15:0] resume_dly;
        logic [15:0] chirp_to;
        logic [3:0] hs_adder;
    } otg_state_s;

endpackage

// [hw/usb_otg_session.sv]
// otg session control and hs timing registers behind an axi4-lite slave
// assumes usb core status inputs are synchronous to aclk; aclk is the usb module clock
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "usb_otg_params.svh"
module usb_otg_session #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic role_is_a,
    input wire logic host_mode,
    input wire logic module_suspended,
    input wire logic session_in_progress,
    input wire logic hs_resume_end,
    input wire logic chirp_begin,
    input wire logic chirp_end,
    input wire logic hs_wait_begin,
    input wire logic hs_wait_end,
    output logic session_drive,
    output logic srp_start,
    output logic soft_disconnect,
    output logic transceiver_normal_en,
    output logic chirp_timeout,
    output logic hs_timeout,
    output logic [17:0] chirp_limit_o,
    output logic [17:0] hs_limit_o
);

    usb_otg_pkg::otg_state_s st_reg;
    usb_otg_pkg::otg_state_s st_next;
    usb_otg_pkg::reg_sel_e wr_sel;
    usb_otg_pkg::reg_sel_e rd_sel;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wfire;
    logic resume_start;
    logic resume_expired;
    logic chirp_running;
    logic hs_running;
    logic [17:0] chirp_limit;
    logic [17:0] hs_limit;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic usb_otg_pkg::reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        case (a)
            `OTG_CTRL_OFS: reg_decode = usb_otg_pkg::sel_ctrl;
            `TMCON1_OFS: reg_decode = usb_otg_pkg::sel_tm1;
            `TMCON2_OFS: reg_decode = usb_otg_pkg::sel_tm2;
            `OTG_STAT_OFS: reg_decode = usb_otg_pkg::sel_stat;
            default: reg_decode = usb_otg_pkg::sel_none;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // rounds up: the timeout is a least time
    function automatic logic [17:0] hs_cycles(input logic [3:0] adder);
        int unsigned bit_ns;
        int unsigned den;
        bit_ns = (`HS_MIN_BITS + `HS_STEP_BITS * int'(adder)) * `HS_STEP_NS;
        den = `HS_STEP_BITS * 1000;
        return 18'((bit_ns * `CLK_MHZ + den - 1) / den);
    endfunction

    assign chirp_limit = {st_reg.chirp_to, 2'b00};
    assign hs_limit = hs_cycles(st_reg.hs_adder);
    assign resume_start = hs_resume_end & host_mode;

    // ----------------------------------------
    // register file and bus slave
    // ----------------------------------------
    always_comb begin
        logic [31:0] tm;
        tm = '0;
        st_next = st_reg;
        st_next.srp_pulse = 1'b0;
        st_next.disc_pulse = 1'b0;
        aw_take = awvalid & st_reg.awready;
        w_take = wvalid & st_reg.wready;
        ar_take = arvalid & st_reg.arready;
        if (aw_take) begin
            st_next.aw_hold = 1'b1;
            st_next.aw_addr = 8'(awaddr);
        end
        if (w_take) begin
            st_next.w_hold = 1'b1;
            st_next.w_data = wdata;
            st_next.w_strb = wstrb;
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        wfire = st_next.aw_hold & st_next.w_hold & ~st_reg.bvalid;
        wr_sel = reg_decode(ADDR_W'(st_next.aw_addr));
        if (wfire) begin
            st_next.aw_hold = 1'b0;
            st_next.w_hold = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `AXI_OKAY;
            case (wr_sel)
                usb_otg_pkg::sel_ctrl: begin
                    if (st_next.w_strb[0]) begin
                        if (role_is_a) begin
                            st_next.session_a = st_next.w_data[`SESSION_BIT];
                        end else if (st_next.w_data[`SESSION_BIT]) begin
                            st_next.srp_pulse = 1'b1;
                        end else if (module_suspended) begin
                            // clear while awake is left without effect
                            st_next.disc_pulse = 1'b1;
                        end
                    end
                end
                usb_otg_pkg::sel_tm1: begin
                    tm = merge({st_reg.resume_dly, st_reg.chirp_to}, st_next.w_data, st_next.w_strb);
                    st_next.resume_dly = tm[31:16];
                    st_next.chirp_to = tm[15:0];
                end
                usb_otg_pkg::sel_tm2: begin
                    tm = merge({28'h000_0000, st_reg.hs_adder}, st_next.w_data, st_next.w_strb);
                    st_next.hs_adder = tm[3:0];
                end
                usb_otg_pkg::sel_stat: begin
                end
                default: begin
                    st_next.bresp = `AXI_SLVERR;
                end
            endcase
        end
        st_next.awready = ~st_next.aw_hold & ~st_next.bvalid;
        st_next.wready = ~st_next.w_hold & ~st_next.bvalid;
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
        rd_sel = reg_decode(araddr);
        if (ar_take) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `AXI_OKAY;
            st_next.rdata = '0;
            case (rd_sel)
                usb_otg_pkg::sel_ctrl: begin
                    st_next.rdata[`SESSION_BIT] = role_is_a ? st_reg.session_a : session_in_progress;
                end
                usb_otg_pkg::sel_tm1: begin
                    st_next.rdata = {st_reg.resume_dly, st_reg.chirp_to};
                end
                usb_otg_pkg::sel_tm2: begin
                    st_next.rdata = {28'h000_0000, st_reg.hs_adder};
                end
                usb_otg_pkg::sel_stat: begin
                    st_next.rdata[4:0] = {st_reg.normal_en, hs_running, chirp_running, module_suspended, role_is_a};
                end
                default: begin
                    st_next.rresp = `AXI_SLVERR;
                end
            endcase
        end
        st_next.arready = ~st_next.rvalid;
        // a new resume end restarts the wait even if the old one just ran out
        if (resume_start) begin
            st_next.normal_en = 1'b0;
        end else if (resume_expired) begin
            st_next.normal_en = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.resume_dly <= 16'(`TMCON1_RST >> `RESUME_DLY_LSB);
            st_reg.chirp_to <= 16'(`TMCON1_RST >> `CHIRP_TO_LSB);
            st_reg.hs_adder <= `HS_ADDER_W'(`TMCON2_RST);
            st_reg.normal_en <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // interval timers
    // ----------------------------------------
    otg_interval_timer #(.WIDTH(18)) resume_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(resume_start),
        .stop(1'b0),
        .limit({2'b00, st_reg.resume_dly}),
        .expired(resume_expired),
        .running()
    );

    otg_interval_timer #(.WIDTH(18)) chirp_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(chirp_begin),
        .stop(chirp_end),
        .limit(chirp_limit),
        .expired(chirp_timeout),
        .running(chirp_running)
    );

    otg_interval_timer #(.WIDTH(18)) hs_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(hs_wait_begin),
        .stop(hs_wait_end),
        .limit(hs_limit),
        .expired(hs_timeout),
        .running(hs_running)
    );

    // limits kept in flops so the outputs stay registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chirp_limit_o <= '0;
            hs_limit_o <= '0;
        end else begin
            chirp_limit_o <= chirp_limit;
            hs_limit_o <= hs_limit;
        end
    end

    assign awready = st_reg.awready;
    assign wready = st_reg.wready;
    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid = st_reg.rvalid;
    assign rdata = st_reg.rdata;
    assign rresp = st_reg.rresp;
    assign session_drive = st_reg.session_a;
    assign srp_start = st_reg.srp_pulse;
    assign soft_disconnect = st_reg.disc_pulse;
    assign transceiver_normal_en = st_reg.normal_en;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    session_write_a: assert property (wfire && wr_sel == usb_otg_pkg::sel_ctrl && st_next.w_strb[0] && role_is_a
        |=> session_drive == $past(st_next.w_data[0]))
        else $error("session drive does not follow a-device write");
    srp_pulse_a: assert property (wfire && wr_sel == usb_otg_pkg::sel_ctrl && st_next.w_strb[0] && !role_is_a
        && st_next.w_data[0] |=> srp_start ##1 !srp_start)
        else $error("session request not a single pulse");
    b_readback_a: assert property (ar_take && rd_sel == usb_otg_pkg::sel_ctrl && !role_is_a
        |=> rvalid && rdata[0] == $past(session_in_progress))
        else $error("b-device session readback wrong");
    disconnect_cause_a: assert property (soft_disconnect |-> $past(module_suspended) && $past(!role_is_a))
        else $error("disconnect without suspended b-device");
    normal_mode_a: assert property ($rose(transceiver_normal_en) |-> $past(resume_expired))
        else $error("normal mode enabled before resume delay");
    resume_clear_a: assert property (resume_start |=> !transceiver_normal_en)
        else $error("normal mode not dropped at resume end");
    chirp_limit_a: assert property (chirp_limit == 18'(`CHIRP_MULT * int'(st_reg.chirp_to)))
        else $error("chirp limit not four times field");
    hs_limit_a: assert property (st_reg.hs_adder == 4'h0 |-> hs_limit == 18'h0_00C0)
        else $error("hs minimum timeout wrong");
    hs_limit_max_a: assert property (st_reg.hs_adder == 4'hF |-> hs_limit == 18'h0_01B9)
        else $error("hs maximum timeout wrong");
    tm2_upper_a: assert property (ar_take && rd_sel == usb_otg_pkg::sel_tm2 |=> rdata[31:4] == 28'h000_0000)
        else $error("unimplemented bits not zero");
    write_resp_a: assert property (wfire |=> bvalid)
        else $error("write response missing");

    srp_seen_c: cover property (srp_start);
    disc_seen_c: cover property (soft_disconnect);
    chirp_to_c: cover property (chirp_timeout);
    hs_to_c: cover property (hs_timeout);

endmodule
